// ==== design/hcc_cursor_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "hcc_regs.svh"

// Overview of operation
// - format comes from indirect control when select is 0, else direct
// - interlace enable uses the field input, xor the field sense invert bit, as the odd/even field
// - vblank after 2048 or 4096 dot clocks between blank rising edges
// - two control bits form cursor ram address bits 9 and 8
// - mode 00 off, 01 three-color, 10 and 11 other formats
// - direct control at 1001 holds the mode, other bits zero, reset 00
// - 12-bit x/y lower-right corner, low bytes and high nibbles
// - each coordinate accepts any value from 0 to 4095
// - zero in x or y puts the cursor off screen
// - position registers are not reset and always accessible
// - indirect control at index 06, read/write, resets to 00
module hcc_cursor_ctrl
   import hcc_pkg::*;
(
   input wire logic I_CLK,
   input wire logic I_RESET,
   // direct register map access
   input wire logic I_DIR_WR,
   input wire logic I_DIR_RD,
   input wire logic [3:0] I_DIR_ADDR,
   input wire logic [7:0] I_DIR_WDATA,
   output logic [7:0] O_DIR_RDATA,
   // indirect register map access
   input wire logic I_IND_WR,
   input wire logic I_IND_RD,
   input wire logic [7:0] I_IND_INDEX,
   input wire logic [7:0] I_IND_WDATA,
   output logic [7:0] O_IND_RDATA,
   // low cursor ram address from the direct-map address register
   input wire logic [7:0] I_CURSOR_RAM_ADDR_LO,
   // video pins
   input wire logic I_BLANK,
   input wire logic I_FIELD,
   // to the cursor engine
   output logic [9:0] O_CURSOR_RAM_ADDR,
   output logic [1:0] O_CURSOR_MODE,
   output logic O_INTERLACE_EN,
   output logic O_FIELD_ODD,
   output logic O_VBLANK,
   output logic [11:0] O_POS_X,
   output logic [11:0] O_POS_Y,
   output logic O_CURSOR_OFF_SCREEN
);

   // ****************************************************************
   // decode
   // ****************************************************************
   // one compare shared by every direct-map register select
   function automatic logic dir_sel(input logic [3:0] addr,
      input logic [3:0] target);
      return addr == target;
   endfunction : dir_sel

   // ****************************************************************
   // registers
   // ****************************************************************
   hcc_ind_ctrl_s ind_ctrl;
   logic [1:0] dir_fmt;
   hcc_pos_s pos;

   wire logic dir_hit_ctrl = dir_sel(I_DIR_ADDR, `HCC_DIR_CTRL_ADDR);
   wire logic dir_hit_xlo = dir_sel(I_DIR_ADDR, `HCC_DIR_XLO_ADDR);
   wire logic dir_hit_xhi = dir_sel(I_DIR_ADDR, `HCC_DIR_XHI_ADDR);
   wire logic dir_hit_ylo = dir_sel(I_DIR_ADDR, `HCC_DIR_YLO_ADDR);
   wire logic dir_hit_yhi = dir_sel(I_DIR_ADDR, `HCC_DIR_YHI_ADDR);
   wire logic ind_hit_ctrl = I_IND_INDEX == `HCC_IND_CTRL_INDEX;

   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         ind_ctrl <= hcc_ind_ctrl_s'(`HCC_IND_CTRL_RESET);
      end else if (I_IND_WR && ind_hit_ctrl) begin
         ind_ctrl <= hcc_ind_ctrl_s'(I_IND_WDATA);
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         dir_fmt <= 2'(`HCC_DIR_CTRL_RESET & `HCC_DIR_CTRL_MASK);
      end else if (I_DIR_WR && dir_hit_ctrl) begin
         dir_fmt <= I_DIR_WDATA[1:0];
      end
   end

   // position has no reset and no display-timing interlock
   // halves land one write at a time, so a move may show a mixed corner
   always_ff @(posedge I_CLK) begin
      if (I_DIR_WR && dir_hit_xlo) begin
         pos.pos_x[7:0] <= I_DIR_WDATA;
      end
      if (I_DIR_WR && dir_hit_xhi) begin
         pos.pos_x[11:8] <= I_DIR_WDATA[3:0];
      end
      if (I_DIR_WR && dir_hit_ylo) begin
         pos.pos_y[7:0] <= I_DIR_WDATA;
      end
      if (I_DIR_WR && dir_hit_yhi) begin
         pos.pos_y[11:8] <= I_DIR_WDATA[3:0];
      end
   end

   // ****************************************************************
   // read paths
   // ****************************************************************
   // unselected addresses read zero, never stale data
   wire logic [7:0] dir_read =
      dir_hit_ctrl ? {6'h00, dir_fmt} :
      dir_hit_xlo ? pos.pos_x[7:0] :
      dir_hit_xhi ? {4'h0, pos.pos_x[11:8]} :
      dir_hit_ylo ? pos.pos_y[7:0] :
      dir_hit_yhi ? {4'h0, pos.pos_y[11:8]} :
      8'h00;
   wire logic [7:0] ind_read = ind_hit_ctrl ? ind_ctrl : 8'h00;

   // read data is held between reads so the host may sample it late
   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         O_DIR_RDATA <= 8'h00;
         O_IND_RDATA <= 8'h00;
      end else begin
         if (I_DIR_RD) begin
            O_DIR_RDATA <= dir_read;
         end
         if (I_IND_RD) begin
            O_IND_RDATA <= ind_read;
         end
      end
   end

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   logic [1:0] blank_sync;
   logic [1:0] field_sync;
   logic blank_prev;

   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         blank_sync <= 2'h0;
         field_sync <= 2'h0;
         blank_prev <= 1'b0;
      end else begin
         blank_sync <= {blank_sync[0], I_BLANK};
         field_sync <= {field_sync[0], I_FIELD};
         blank_prev <= blank_sync[1];
      end
   end

   // ****************************************************************
   // vertical blank detection
   // ****************************************************************
   // counter saturates at the long threshold so a stopped display
   // cannot wrap it back under the limit
   logic [12:0] gap_count;
   wire logic blank_rise = blank_sync[1] & ~blank_prev;
   wire logic [12:0] vbl_limit =
      ind_ctrl.vblank_detect_len ? `HCC_VBL_LONG : `HCC_VBL_SHORT;
   wire logic [12:0] next_gap_count = blank_rise ? 13'h0000 :
      (gap_count == `HCC_VBL_LONG) ? gap_count : 13'(gap_count + 13'h0001);
   wire logic next_vblank = ~blank_rise && (next_gap_count >= vbl_limit);

   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         gap_count <= 13'h0000;
      end else begin
         gap_count <= next_gap_count;
      end
   end

   // ****************************************************************
   // cursor engine outputs
   // ****************************************************************
   wire logic [1:0] ind_fmt = {ind_ctrl.cursor_fmt_hi, ind_ctrl.cursor_fmt_lo};
   wire hcc_fmt_e next_mode =
      hcc_fmt_e'(ind_ctrl.ctrl_reg_select ? dir_fmt : ind_fmt);
   wire logic next_field_odd =
      field_sync[1] ^ ind_ctrl.field_sense_invert;
   wire logic next_off_screen =
      (pos.pos_x == 12'h000) || (pos.pos_y == 12'h000);

   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         O_CURSOR_MODE <= HCC_FMT_OFF;
         O_INTERLACE_EN <= 1'b0;
         O_CURSOR_RAM_ADDR <= 10'h000;
      end else begin
         O_CURSOR_MODE <= next_mode;
         O_INTERLACE_EN <= ind_ctrl.interlace_cursor_en;
         O_CURSOR_RAM_ADDR <= {ind_ctrl.cursor_ram_addr_b9,
            ind_ctrl.cursor_ram_addr_b8, I_CURSOR_RAM_ADDR_LO};
      end
   end

   // field and blank indicators lag their pins by the synchroniser depth plus one output register
   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         O_FIELD_ODD <= 1'b0;
         O_VBLANK <= 1'b0;
      end else begin
         O_FIELD_ODD <= next_field_odd;
         O_VBLANK <= next_vblank;
      end
   end

   // position outputs follow the unreset position registers
   always_ff @(posedge I_CLK) begin
      O_POS_X <= pos.pos_x;
      O_POS_Y <= pos.pos_y;
      O_CURSOR_OFF_SCREEN <= next_off_screen;
   end

endmodule : hcc_cursor_ctrl
`default_nettype wire

// ==== design/hcc_regs.svh ====
`ifndef HCC_REGS_SVH
`define HCC_REGS_SVH

// ****************************************************************
// direct map addresses (4-bit register select)
// ****************************************************************
`define HCC_DIR_CTRL_ADDR 4'h9
`define HCC_DIR_XLO_ADDR 4'hc
`define HCC_DIR_XHI_ADDR 4'hd
`define HCC_DIR_YLO_ADDR 4'he
`define HCC_DIR_YHI_ADDR 4'hf

// ****************************************************************
// indirect map index
// ****************************************************************
`define HCC_IND_CTRL_INDEX 8'h06

// ****************************************************************
// indirect control field positions
// ****************************************************************
`define HCC_CCR_SEL_BIT 7
`define HCC_CCR_FINV_BIT 6
`define HCC_CCR_ILACE_BIT 5
`define HCC_CCR_VBLEN_BIT 4
`define HCC_CCR_RAMHI_MSB 3
`define HCC_CCR_RAMHI_LSB 2
`define HCC_CCR_FMT_MSB 1
`define HCC_CCR_FMT_LSB 0

// ****************************************************************
// reset values and masks
// ****************************************************************
`define HCC_IND_CTRL_RESET 8'h00
`define HCC_DIR_CTRL_RESET 8'h00
`define HCC_DIR_CTRL_MASK 8'h03
`define HCC_POS_HI_MASK 8'h0f

// ****************************************************************
// vertical blank detection thresholds, in dot clocks
// ****************************************************************
`define HCC_VBL_SHORT 13'h0800
`define HCC_VBL_LONG 13'h1000

`endif

// ==== design/hcc_pkg.sv ====
package hcc_pkg;

   // cursor ram interpretation format
   typedef enum logic [1:0] {
      HCC_FMT_OFF = 2'h0,
      HCC_FMT_THREE_COLOR = 2'h1,
      HCC_FMT_ALT_A = 2'h2,
      HCC_FMT_ALT_B = 2'h3
   } hcc_fmt_e;

   typedef struct packed {
      logic ctrl_reg_select;
      logic field_sense_invert;
      logic interlace_cursor_en;
      logic vblank_detect_len;
      logic cursor_ram_addr_b9;
      logic cursor_ram_addr_b8;
      logic cursor_fmt_hi;
      logic cursor_fmt_lo;
   } hcc_ind_ctrl_s;

   typedef struct packed {
      logic [11:0] pos_x;
      logic [11:0] pos_y;
   } hcc_pos_s;

endpackage : hcc_pkg

// ==== dv/hcc_cursor_ctrl_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
// ********
// register bank checks
// ********
module hcc_cursor_ctrl_chk (
   input wire logic I_CLK, I_RESET, I_DIR_RD, I_IND_WR, I_IND_RD, I_BLANK,
   input wire logic [3:0] I_DIR_ADDR,
   input wire logic [7:0] I_IND_INDEX, I_IND_WDATA, O_DIR_RDATA, O_IND_RDATA,
   input wire logic [1:0] O_CURSOR_MODE,
   input wire logic [9:0] O_CURSOR_RAM_ADDR,
   input wire logic [11:0] O_POS_X, O_POS_Y,
   input wire logic O_INTERLACE_EN, O_VBLANK, O_CURSOR_OFF_SCREEN
);
   default clocking @(posedge I_CLK); endclocking
   default disable iff (I_RESET);
   sequence wr6;
      I_IND_WR && I_IND_INDEX == 8'h06 ##1 !I_IND_WR;
   endsequence
   a_mode_ind: assert property (
      (I_IND_WR && I_IND_INDEX == 8'h06 && !I_IND_WDATA[7] ##1 !I_IND_WR)
      |=> ##1 O_CURSOR_MODE == $past(I_IND_WDATA[1:0], 3))
      else $error("mode differs from indirect control");
   a_ram_addr_hi: assert property (
      wr6 |=> ##1 O_CURSOR_RAM_ADDR[9:8] == $past(I_IND_WDATA[3:2], 3))
      else $error("ram address high bits wrong");
   a_ilace_bit: assert property (
      wr6 |=> ##1 O_INTERLACE_EN == $past(I_IND_WDATA[5], 3))
      else $error("interlace enable wrong");
   a_pos_hi_zero: assert property (
      I_DIR_RD && I_DIR_ADDR[3:2] == 2'h3 && I_DIR_ADDR[0]
      |=> O_DIR_RDATA[7:4] == 4'h0) else $error("position high nibble set");
   a_dir_rsv_zero: assert property (
      I_DIR_RD && I_DIR_ADDR == 4'h9 |=> O_DIR_RDATA[7:2] == 6'h00)
      else $error("direct control reserved bits set");
   a_ind_unmapped: assert property (
      I_IND_RD && I_IND_INDEX != 8'h06 |=> O_IND_RDATA == 8'h00)
      else $error("unmapped index read not zero");
   a_off_zero: assert property (
      $rose(O_CURSOR_OFF_SCREEN) |-> O_POS_X == 12'h000 ||
      O_POS_Y == 12'h000 || $past(O_POS_X) == 12'h000 ||
      $past(O_POS_Y) == 12'h000) else $error("off screen without zero");
   a_vbl_clear: assert property (
      $rose(I_BLANK) |-> ##[1:5] !O_VBLANK)
      else $error("vblank not ended by blank rise");
   a_reset_clear: assert property (disable iff (1'b0)
      I_RESET |=> O_CURSOR_MODE == 2'h0 && !O_VBLANK && O_IND_RDATA == 8'h00)
      else $error("reset values wrong");
   cover property (wr6);
   cover property ($rose(O_VBLANK));
   cover property ($rose(O_CURSOR_OFF_SCREEN));
endmodule : hcc_cursor_ctrl_chk
bind hcc_cursor_ctrl hcc_cursor_ctrl_chk i_chk (.*);
`default_nettype wire

// ==== dv/hcc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ********
// host side of both register maps
// ********
module hcc_host_model (
   input wire logic I_CLK,
   input wire logic [7:0] O_DIR_RDATA, O_IND_RDATA,
   output logic I_DIR_WR, I_DIR_RD, I_IND_WR, I_IND_RD,
   output logic [3:0] I_DIR_ADDR,
   output logic [7:0] I_DIR_WDATA, I_IND_INDEX, I_IND_WDATA
);
   initial {I_DIR_WR, I_DIR_RD, I_IND_WR, I_IND_RD} = 4'h0;
   initial {I_DIR_ADDR, I_DIR_WDATA, I_IND_INDEX, I_IND_WDATA} = 28'h0;
   task acc(input logic ind, wr, input logic [7:0] a, d,
      output logic [7:0] q);
      @(posedge I_CLK);
      I_DIR_WR <= !ind && wr;
      I_DIR_RD <= !ind && !wr;
      I_IND_WR <= ind && wr;
      I_IND_RD <= ind && !wr;
      I_DIR_ADDR <= a[3:0];
      I_IND_INDEX <= a;
      {I_DIR_WDATA, I_IND_WDATA} <= {d, d};
      @(posedge I_CLK);
      {I_DIR_WR, I_DIR_RD, I_IND_WR, I_IND_RD} <= 4'h0;
      // released data lines must not keep the last value
      {I_DIR_WDATA, I_IND_WDATA} <= ~{d, d};
      @(posedge I_CLK);
      q = ind ? O_IND_RDATA : O_DIR_RDATA;
   endtask : acc
endmodule : hcc_host_model
`default_nettype wire

// ==== dv/hcc_cursor_ctrl_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// ********
// register bank bench
// ********
module hcc_cursor_ctrl_tb;
   import hcc_pkg::*;
   logic I_CLK = 0, I_RESET = 1, I_BLANK = 0, I_FIELD = 0;
   logic I_DIR_WR, I_DIR_RD, I_IND_WR, I_IND_RD, O_INTERLACE_EN;
   logic O_FIELD_ODD, O_VBLANK, O_CURSOR_OFF_SCREEN;
   logic [3:0] I_DIR_ADDR;
   logic [7:0] I_DIR_WDATA, I_IND_INDEX, I_IND_WDATA, O_DIR_RDATA, O_IND_RDATA;
   logic [7:0] I_CURSOR_RAM_ADDR_LO = 0, dcc, q, ra;
   logic [9:0] O_CURSOR_RAM_ADDR;
   logic [1:0] O_CURSOR_MODE;
   logic [11:0] O_POS_X, O_POS_Y, x, y;
   int bad_count = 0, cmp_count = 0, seed = 32'he7e8;
   hcc_ind_ctrl_s cursor_ctrl_indirect;
   always #4 I_CLK = ~I_CLK;
   hcc_cursor_ctrl i_hcc_cursor_ctrl (.*);
   hcc_host_model i_hcc_host_model (.*);
   task chk(string n, logic [11:0] s, e);
      cmp_count++;
      if (s !== e) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task end_sim;
      $display("mismatches %0d compares %0d", bad_count, cmp_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_sim
   function logic [1:0] exp_mode(hcc_ind_ctrl_s c, logic [7:0] d);
      return c.ctrl_reg_select ? d[1:0] : {c.cursor_fmt_hi, c.cursor_fmt_lo};
   endfunction : exp_mode
   task acc(logic ind, wr, logic [7:0] a, d);
      i_hcc_host_model.acc(ind, wr, a, d, q);
   endtask : acc
   task cyc(int n);
      repeat (n) @(posedge I_CLK);
   endtask : cyc
   initial begin
      cyc(4);
      I_RESET <= 0;
      acc(1, 0, 8'h06, 0);
      chk("ind ctrl reset", q, 0);
      acc(0, 0, 8'h09, 0);
      chk("dir ctrl reset", q, 0);
      $display("reset test done");
      for (int i = 0; i < 8; i++) begin
         cursor_ctrl_indirect = $random(seed);
         dcc = $random(seed);
         cursor_ctrl_indirect.ctrl_reg_select = i[2];
         {cursor_ctrl_indirect.cursor_fmt_hi, cursor_ctrl_indirect.cursor_fmt_lo} = i[1:0];
         dcc[1:0] = ~i[1:0];
         x = (i == 0) ? 12'h0 : 12'h040 + 12'($random(seed));
         y = (i == 1) ? 12'h0 : (i == 2) ? 12'hfff : 12'h040 + 12'(i);
         ra = 8'($random(seed));
         I_CURSOR_RAM_ADDR_LO <= ra;
         I_FIELD <= i[0];
         acc(1, 1, 8'h06, cursor_ctrl_indirect);
         acc(0, 1, 8'h09, dcc);
         acc(0, 1, 8'h0c, x[7:0]);
         acc(0, 1, 8'h0d, {4'($random(seed)), x[11:8]});
         acc(0, 1, 8'h0e, y[7:0]);
         acc(0, 1, 8'h0f, {4'($random(seed)), y[11:8]});
         cyc(3);
         chk("mode", O_CURSOR_MODE, exp_mode(cursor_ctrl_indirect, dcc));
         chk("ram addr", O_CURSOR_RAM_ADDR, {cursor_ctrl_indirect[3:2], ra});
         chk("interlace", O_INTERLACE_EN, cursor_ctrl_indirect[5]);
         chk("field", O_FIELD_ODD, i[0] ^ cursor_ctrl_indirect[6]);
         chk("pos x", O_POS_X, x);
         chk("pos y", O_POS_Y, y);
         chk("off screen", O_CURSOR_OFF_SCREEN, x == 0 || y == 0);
         acc(1, 0, 8'h06, 0);
         chk("ind ctrl", q, cursor_ctrl_indirect);
         acc(0, 0, 8'h09, 0);
         chk("dir ctrl", q, dcc & 8'h03);
         acc(0, 0, 8'h0f, 0);
         chk("y high", q, y[11:8]);
         acc(0, 0, 8'h0c, 0);
         chk("x low", q, x[7:0]);
      end
      acc(1, 1, 8'h07, 8'h5a);
      acc(1, 0, 8'h07, 0);
      chk("unmapped index", q, 0);
      $display("register test done");
      for (int b = 0; b < 2; b++) begin
         cursor_ctrl_indirect.vblank_detect_len = b[0];
         acc(1, 1, 8'h06, cursor_ctrl_indirect);
         I_BLANK <= 1;
         cyc(2);
         I_BLANK <= 0;
         cyc((2048 << b) - 8);
         chk("vblank early", O_VBLANK, 0);
         cyc(24);
         chk("vblank", O_VBLANK, 1);
         I_BLANK <= 1;
         cyc(8);
         chk("vblank end", O_VBLANK, 0);
         I_BLANK <= 0;
      end
      $display("vblank test done");
      I_RESET <= 1;
      cyc(3);
      I_RESET <= 0;
      acc(1, 0, 8'h06, 0);
      chk("ctrl after reset", q, 0);
      chk("pos kept", O_POS_Y, y);
      $display("second reset test done");
      end_sim();
   end
   initial begin
      cyc(20000);
      bad_count++;
      end_sim();
   end
endmodule : hcc_cursor_ctrl_tb
`default_nettype wire
